// file: design/sto_pkg.sv
package sto_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned FILTER_US = 2000;
  localparam int unsigned FILTER_CYCLES = FILTER_US * CLK_MHZ + 1;
  localparam int unsigned RESPONSE_MS = 30;
  localparam int unsigned MONITOR_MS = 5;
  localparam int unsigned MONITOR_CYCLES = MONITOR_MS * 1000 * CLK_MHZ;
  localparam int unsigned OPEN_S = 10;
  localparam longint unsigned OPEN_CYCLES =
    64'(OPEN_S) * 64'd1000000 * 64'(CLK_MHZ) + 64'd1;
  localparam int unsigned DIAG_MS = 19;
  localparam int unsigned DIAG_CYCLES = DIAG_MS * 1000 * CLK_MHZ;
  localparam int unsigned MISMATCH_MS = 20;
  localparam int unsigned MISMATCH_CYCLES = MISMATCH_MS * 1000 * CLK_MHZ;
  localparam int unsigned FEEDBACK_CYCLES = 16;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic RESET_SYNC = 1'b0;
  localparam logic RESET_FILTERED = 1'b0;

endpackage

// file: design/sto_channel.sv
`timescale 1ns/1ps
`default_nettype none

module sto_channel
  import sto_pkg::*;
#(
  parameter int unsigned FILTER_LEN = FILTER_CYCLES,
  parameter longint unsigned OPEN_LEN = OPEN_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic filtered_on,
  output logic open_alarm
);

  // ==========================================================
  // synchroniser
  // ==========================================================
  logic sync_first;
  logic sync_second;
  logic [31:0] low_count;
  logic [39:0] open_count;

  // two flops; only the second is read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_first <= RESET_SYNC;
      sync_second <= RESET_SYNC;
    end else begin
      sync_first <= pin_in;
      sync_second <= sync_first;
    end
  end

  // ==========================================================
  // filter
  // ==========================================================
  // off only after low longer than filter time; short pulses ignored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_count <= 32'h0;
      filtered_on <= RESET_FILTERED;
    end else if (sync_second) begin
      low_count <= 32'h0;
      filtered_on <= 1'b1;
    end else if (low_count >= 32'(FILTER_LEN - 1)) begin
      filtered_on <= 1'b0;
    end else begin
      low_count <= low_count + 32'h1;
    end
  end

  // disconnected-input timer, sticky until reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      open_count <= 40'h0;
      open_alarm <= 1'b0;
    end else if (sync_second) begin
      open_count <= 40'h0;
    end else if (open_count >= 40'(OPEN_LEN - 1)) begin
      open_alarm <= 1'b1;
    end else begin
      open_count <= open_count + 40'h1;
    end
  end

endmodule

`default_nettype wire

// file: design/sto_gating.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - safe state gates all PWM in hardware
// - PWM removed well under 30 ms
// - input off after low over 2 ms
// - any diagnosed fault forces safe state
// - single channel test plus reaction below 30ms
// - self test repeats every 19 ms
// - single part plus two redundant channels cut
// - input open alarm after 10 s low
// - separate circuit fault alarm on damage
// - both off safe; one off alarm
// - monitor output on only when both off
module sto_gating
  import sto_pkg::*;
#(
  parameter int unsigned PWM_WIDTH = 6,
  parameter int unsigned FILTER_LEN = FILTER_CYCLES,
  parameter longint unsigned OPEN_LEN = OPEN_CYCLES,
  parameter int unsigned DIAG_LEN = DIAG_CYCLES,
  parameter int unsigned MISMATCH_LEN = MISMATCH_CYCLES,
  parameter int unsigned FEEDBACK_LEN = FEEDBACK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic [PWM_WIDTH-1:0] pwm_in,
  input wire logic [PWM_WIDTH-1:0] gate_feedback,
  output logic [PWM_WIDTH-1:0] pwm_out,
  output logic safe_torque_off,
  output logic safe_state_indication,
  output logic fault_monitor_output,
  output logic alarm_safety_input_open,
  output logic alarm_safety_circuit_fault,
  output logic alarm_channel_mismatch
);

  // ==========================================================
  // input channels
  // ==========================================================
  logic on_a;
  logic on_b;
  logic open_a;
  logic open_b;

  sto_channel #(
    .FILTER_LEN(FILTER_LEN),
    .OPEN_LEN(OPEN_LEN)
  ) u_chan_a (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(safety_input_a),
    .filtered_on(on_a),
    .open_alarm(open_a)
  );

  sto_channel #(
    .FILTER_LEN(FILTER_LEN),
    .OPEN_LEN(OPEN_LEN)
  ) u_chan_b (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(safety_input_b),
    .filtered_on(on_b),
    .open_alarm(open_b)
  );

  // ==========================================================
  // feedback synchroniser
  // ==========================================================
  logic [PWM_WIDTH-1:0] fb_first;
  logic [PWM_WIDTH-1:0] fb_second;

  // readback of the gated driver lines from the power stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fb_first <= '0;
      fb_second <= '0;
    end else begin
      fb_first <= gate_feedback;
      fb_second <= fb_first;
    end
  end

  // ==========================================================
  // periodic self test
  // ==========================================================
  typedef enum logic [1:0] {STO_IDLE, STO_TEST, STO_CHECK} sto_diag_t;
  sto_diag_t diag_state;
  logic [31:0] diag_count;
  logic [7:0] fb_count;
  logic test_block;
  logic diag_fault;
  logic gate_open;

  // short forced cutoff pulse, then check that feedback went quiet
  // the pulse is a few cycles long, far below the response budget,
  // so a healthy drive loses torque only briefly
  always_ff @(posedge core_clk) begin
    if (reset) begin
      diag_state <= STO_IDLE;
      diag_count <= 32'h0;
      fb_count <= 8'h0;
      test_block <= 1'b0;
      diag_fault <= 1'b0;
    end else begin
      case (diag_state)
        STO_IDLE: begin
          test_block <= 1'b0;
          if (diag_count >= 32'(DIAG_LEN - 1)) begin
            diag_count <= 32'h0;
            diag_state <= STO_TEST;
          end else begin
            diag_count <= diag_count + 32'h1;
          end
        end
        STO_TEST: begin
          test_block <= 1'b1;
          fb_count <= 8'h0;
          diag_state <= STO_CHECK;
        end
        STO_CHECK: begin
          if (fb_count >= 8'(FEEDBACK_LEN - 1)) begin
            if (fb_second != '0) begin
              diag_fault <= 1'b1;
            end
            test_block <= 1'b0;
            diag_state <= STO_IDLE;
          end else begin
            fb_count <= fb_count + 8'h1;
          end
        end
        default: begin
          diag_state <= STO_IDLE;
          test_block <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // channel mismatch and circuit fault
  // ==========================================================
  logic [31:0] mismatch_count;
  logic mismatch_fault;

  // one channel off too long is treated as discrepancy
  // a lone open channel can hide a welded contact on the other one,
  // so a long disagreement latches a circuit fault
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mismatch_count <= 32'h0;
      mismatch_fault <= 1'b0;
    end else if (on_a == on_b) begin
      mismatch_count <= 32'h0;
    end else if (mismatch_count >= 32'(MISMATCH_LEN - 1)) begin
      mismatch_fault <= 1'b1;
    end else begin
      mismatch_count <= mismatch_count + 32'h1;
    end
  end

  // alarm when one channel alone is off
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_channel_mismatch <= 1'b0;
    end else begin
      alarm_channel_mismatch <= on_a ^ on_b;
    end
  end

  // sticky alarms, distinct outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_safety_input_open <= 1'b0;
      alarm_safety_circuit_fault <= 1'b0;
    end else begin
      alarm_safety_input_open <= open_a | open_b;
      alarm_safety_circuit_fault <= diag_fault | mismatch_fault;
    end
  end

  // ==========================================================
  // cutoff
  // ==========================================================
  // both redundant channels and the single diagnostic part must agree
  // faults are sticky: closing the inputs again cannot restore torque
  // until the drive is reset
  assign gate_open = on_a & on_b & ~diag_fault & ~mismatch_fault;

  // registered gate, one cycle after filter decision
  // pwm_out and the flag share one edge; only the self-test pulse cuts pwm_out while the flag stays low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwm_out <= '0;
      safe_torque_off <= 1'b1;
    end else begin
      pwm_out <= (gate_open & ~test_block) ? pwm_in : '0;
      safe_torque_off <= ~gate_open;
    end
  end

  // safe indication and monitor output only for both channels off
  // the monitor output follows the inputs only, not the fault state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      safe_state_indication <= 1'b0;
      fault_monitor_output <= 1'b0;
    end else begin
      safe_state_indication <= ~on_a & ~on_b;
      fault_monitor_output <= ~on_a & ~on_b;
    end
  end

endmodule

`default_nettype wire

// file: testbench/sto_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// torque off checker
module sto_monitor #(
  parameter int unsigned PWM_WIDTH = 6,
  parameter int unsigned FILTER_LEN = 20,
  parameter longint unsigned OPEN_LEN = 200
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic [PWM_WIDTH-1:0] pwm_out,
  input wire logic safe_torque_off,
  input wire logic safe_state_indication,
  input wire logic fault_monitor_output,
  input wire logic alarm_safety_input_open,
  input wire logic alarm_safety_circuit_fault,
  input wire logic alarm_channel_mismatch
);
  logic [31:0] lo_a;
  logic [31:0] lo_b;
  logic safe;
  logic flt;
  // low run length of each input
  always_ff @(posedge core_clk) begin
    lo_a <= (reset || safety_input_a) ? 32'h0 : lo_a + 32'h1;
    lo_b <= (reset || safety_input_b) ? 32'h0 : lo_b + 32'h1;
  end
  // short names
  assign safe = safe_state_indication;
  assign flt = alarm_safety_circuit_fault;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_gate_pwm_off: assert property (safe_torque_off |-> pwm_out == '0)
    else $error("pwm passes in safe state");
  a_both_off_safe: assert property (
    lo_a > FILTER_LEN + 4 && lo_b > FILTER_LEN + 4
    |-> safe_torque_off && safe && fault_monitor_output)
    else $error("no safe state after both off");
  a_filter_rise: assert property (
    $rose(safe) && !$past(safe_torque_off)
    |-> lo_a >= FILTER_LEN && lo_b >= FILTER_LEN)
    else $error("safe state before filter time");
  a_monitor_both: assert property (
    fault_monitor_output |-> safe && !alarm_channel_mismatch)
    else $error("monitor output without both off");
  a_one_off_cut: assert property (alarm_channel_mismatch |-> safe_torque_off)
    else $error("one input off leaves torque on");
  a_fault_cut: assert property (flt && $past(flt) |-> safe_torque_off)
    else $error("fault leaves torque on");
  a_open_time: assert property (
    $rose(alarm_safety_input_open) |-> lo_a > OPEN_LEN || lo_b > OPEN_LEN)
    else $error("open alarm too early");
  a_fault_sticky: assert property (flt |=> flt)
    else $error("circuit fault alarm dropped");
  c_safe: cover property (safe);
  c_fault: cover property (flt);
  c_open: cover property (alarm_safety_input_open);
  c_mismatch: cover property (alarm_channel_mismatch);
endmodule
`default_nettype wire

// file: testbench/sto_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// safety switch and power stage
module sto_far_side (
  input wire logic core_clk,
  input wire logic want_a,
  input wire logic want_b,
  input wire logic stuck,
  input wire logic [5:0] pwm_out,
  output logic safety_input_a,
  output logic safety_input_b,
  output logic [5:0] gate_feedback
);
  logic [5:0] d1;
  // contacts follow the commanded levels
  assign safety_input_a = want_a;
  assign safety_input_b = want_b;
  // gate readback two cycles late, or shorted on command
  always_ff @(posedge core_clk) begin
    d1 <= pwm_out;
    gate_feedback <= stuck ? 6'h3f : d1;
  end
endmodule
`default_nettype wire

// file: testbench/tb_safe_torque_off_gating.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// torque off bench
module tb_safe_torque_off_gating;
  localparam int unsigned FL = 20;
  localparam longint unsigned OL = 200;
  localparam int unsigned DL = 100;
  localparam int unsigned ML = 300;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic stuck = 1'b0;
  logic [5:0] pwm_in = 6'h00;
  logic [5:0] gate_feedback, pwm_out;
  logic safety_input_a, safety_input_b, safe_torque_off;
  logic safe_state_indication, fault_monitor_output, alarm_channel_mismatch;
  logic alarm_safety_input_open, alarm_safety_circuit_fault;
  int n_errors = 0;
  int checks = 0;
  // clock and moving pwm pattern
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) pwm_in <= #1 pwm_in + 6'h01;
  sto_gating #(
    .FILTER_LEN(FL),
    .OPEN_LEN(OL),
    .DIAG_LEN(DL),
    .MISMATCH_LEN(ML)
  ) uut (
    .core_clk(core_clk),
    .reset(reset),
    .safety_input_a(safety_input_a),
    .safety_input_b(safety_input_b),
    .pwm_in(pwm_in),
    .gate_feedback(gate_feedback),
    .pwm_out(pwm_out),
    .safe_torque_off(safe_torque_off),
    .safe_state_indication(safe_state_indication),
    .fault_monitor_output(fault_monitor_output),
    .alarm_safety_input_open(alarm_safety_input_open),
    .alarm_safety_circuit_fault(alarm_safety_circuit_fault),
    .alarm_channel_mismatch(alarm_channel_mismatch)
  );
  sto_far_side far (.core_clk(core_clk), .want_a(want_a), .want_b(want_b),
    .stuck(stuck), .pwm_out(pwm_out), .safety_input_a(safety_input_a),
    .safety_input_b(safety_input_b), .gate_feedback(gate_feedback));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_pwm(input string what, input logic [5:0] e,
    input logic [5:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic t_on();
    want_a = 1'b1;
    want_b = 1'b1;
    step(FL);
    chk("sto", 1'b0, safe_torque_off);
    chk("mon", 1'b0, fault_monitor_output);
  endtask
  task automatic t_short();
    want_a = 1'b0;
    step(FL - 3);
    want_a = 1'b1;
    repeat (8) begin
      step(1);
      chk("sto", 1'b0, safe_torque_off);
    end
  endtask
  task automatic t_both_off();
    want_a = 1'b0;
    want_b = 1'b0;
    step(FL);
    chk("mon", 1'b0, fault_monitor_output);
    step(5);
    chk("sto", 1'b1, safe_torque_off);
    chk("ind", 1'b1, safe_state_indication);
    chk("mon", 1'b1, fault_monitor_output);
    chk_pwm("pwm", 6'h00, pwm_out);
  endtask
  task automatic t_one_off();
    want_b = 1'b0;
    step(FL + 6);
    chk("mis", 1'b1, alarm_channel_mismatch);
    chk("sto", 1'b1, safe_torque_off);
    chk("mon", 1'b0, fault_monitor_output);
  endtask
  task automatic t_fault();
    stuck = 1'b1;
    step(140);
    chk("flt", 1'b1, alarm_safety_circuit_fault);
    chk("sto", 1'b1, safe_torque_off);
    chk("open", 1'b0, alarm_safety_input_open);
    stuck = 1'b0;
  endtask
  task automatic t_open();
    want_a = 1'b0;
    want_b = 1'b0;
    step(OL + 10);
    chk("open", 1'b1, alarm_safety_input_open);
    chk("flt", 1'b0, alarm_safety_circuit_fault);
    t_on();
    chk("open", 1'b1, alarm_safety_input_open);
  endtask
  task automatic t_mismatch();
    want_b = 1'b0;
    step(ML + FL + 10);
    chk("flt", 1'b1, alarm_safety_circuit_fault);
    chk("sto", 1'b1, safe_torque_off);
    want_b = 1'b1;
    step(FL);
    chk("mis", 1'b0, alarm_channel_mismatch);
    chk("sto", 1'b1, safe_torque_off);
    chk("flt", 1'b1, alarm_safety_circuit_fault);
  endtask
  // main sequence
  initial begin
    step(2);
    reset = 1'b0;
    chk("sto", 1'b1, safe_torque_off);
    t_on();
    t_short();
    t_both_off();
    t_on();
    t_one_off();
    t_on();
    t_fault();
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    t_open();
    t_mismatch();
    end_of_test();
  end
  // watchdog
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
endmodule
bind sto_gating sto_monitor #(
  .PWM_WIDTH(PWM_WIDTH),
  .FILTER_LEN(FILTER_LEN),
  .OPEN_LEN(OPEN_LEN)
) mon (
  .core_clk(core_clk),
  .reset(reset),
  .safety_input_a(safety_input_a),
  .safety_input_b(safety_input_b),
  .pwm_out(pwm_out),
  .safe_torque_off(safe_torque_off),
  .safe_state_indication(safe_state_indication),
  .fault_monitor_output(fault_monitor_output),
  .alarm_safety_input_open(alarm_safety_input_open),
  .alarm_safety_circuit_fault(alarm_safety_circuit_fault),
  .alarm_channel_mismatch(alarm_channel_mismatch)
);
`default_nettype wire
